// File: core/event_router_pkg.sv
// Shared constants and types for the fixed event router
package event_router_pkg;
  localparam int NUM_CMP      = 8;
  localparam int NUM_PWM      = 36;
  localparam int NUM_PA_GRP   = 3;
  localparam int NUM_PB_GRP   = 2;
  localparam int NUM_AST_EV   = 3;
  localparam int PWM_IDX_W    = 6;
  localparam int CMP_CFG_W    = 2;
  localparam int ADC_TRG_W    = 3;
  // Comparator to pulse-width channel map
  localparam logic [PWM_IDX_W-1:0] CMP_TO_PWM [NUM_CMP] = '{
    6'h00, 6'h06, 6'h08, 6'h09, 6'h0B, 6'h0E, 6'h13, 6'h14};
  localparam logic [CMP_CFG_W-1:0] CMP_CFG_EVENT_SINGLE = 2'h3;
  localparam logic [ADC_TRG_W-1:0] ADC_TRG_PERIPH_EVENT = 3'h7;
  localparam logic                 EN_RESET             = 1'h0;
  localparam logic                 PULSE_RESET          = 1'h0;
  typedef logic [NUM_CMP-1:0] cmp_vec_t;
endpackage

// File: core/event_gate_if.sv
// Bundle carrying gated generator events between router modules
`timescale 1ns/1ps
interface event_gate_if;
  import event_router_pkg::*;
  cmp_vec_t               cmp_up;
  cmp_vec_t               cmp_dn;
  logic [NUM_PA_GRP-1:0]  pa_chg;
  logic [NUM_PB_GRP-1:0]  pb_chg;
  logic [NUM_AST_EV-1:0]  ast_ev;
  logic                   pwm0_match;
  modport src (output cmp_up, cmp_dn, pa_chg, pb_chg, ast_ev, pwm0_match);
  modport dst (input  cmp_up, cmp_dn, pa_chg, pb_chg, ast_ev, pwm0_match);
endinterface

// File: core/event_gen_gate.sv
// Generator-side enable gating of raw events
`timescale 1ns/1ps
module event_gen_gate
  import event_router_pkg::*;
(
  // Raw events
  input  wire cmp_vec_t              raw_cmp_up,
  input  wire cmp_vec_t              raw_cmp_dn,
  input  wire logic [NUM_PA_GRP-1:0] raw_pa_chg,
  input  wire logic [NUM_PB_GRP-1:0] raw_pb_chg,
  input  wire logic [NUM_AST_EV-1:0] raw_ast_ev,
  input  wire logic                  raw_pwm0_match,
  // Generator enables
  input  wire cmp_vec_t              en_cmp_up,
  input  wire cmp_vec_t              en_cmp_dn,
  input  wire logic [NUM_PA_GRP-1:0] en_pa_chg,
  input  wire logic [NUM_PB_GRP-1:0] en_pb_chg,
  input  wire logic [NUM_AST_EV-1:0] en_ast_ev,
  input  wire logic                  en_pwm0_match,
  // Gated events
  event_gate_if.src                  gated
);
  always_comb begin
    gated.cmp_up     = raw_cmp_up & en_cmp_up;
    gated.cmp_dn     = raw_cmp_dn & en_cmp_dn;
    gated.pa_chg     = raw_pa_chg & en_pa_chg;
    gated.pb_chg     = raw_pb_chg & en_pb_chg;
    gated.ast_ev     = raw_ast_ev & en_ast_ev;
    gated.pwm0_match = raw_pwm0_match & en_pwm0_match;
  end
endmodule

// File: core/fixed_event_router.sv
// Hard-wired peripheral event network with generator and user gating
`timescale 1ns/1ps
// Functional notes
// - Routing is fixed wiring; no selection register exists.
// - Each path gated by a generator enable and a user enable.
// - Comparator positive-above event increments mapped pulse-width channel duty.
// - Comparator negative-above event decrements same mapped channel; synchronous.
// - Every comparator negative-above event also goes to touch module.
// - Port A pin groups trigger capture on first timer channels 0..2.
// - Port B pin groups trigger capture on second timer channels 0,1.
// - Timer events start comparator measurement when config and enable allow.
// - Timer events start ADC conversion when trigger mode is peripheral event.
// - Timer events each trigger one touch detection iteration.
// - Pulse-width channel 0 match starts comparator and ADC, same conditions.
// - One generator event fans out to all connected users.
// - Only the three timer events are ORed together; channel 0 match and comparator events keep separate outputs.
// - Only users with their input enabled react.
// - Asynchronous timer events pass combinationally, needing no running clock.
module fixed_event_router
  import event_router_pkg::*;
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Raw generator events
  input  wire event_router_pkg::cmp_vec_t cmp_pos_above,
  input  wire event_router_pkg::cmp_vec_t cmp_neg_above,
  input  wire logic [event_router_pkg::NUM_PA_GRP-1:0] pa_pin_change,
  input  wire logic [event_router_pkg::NUM_PB_GRP-1:0] pb_pin_change,
  input  wire logic [event_router_pkg::NUM_AST_EV-1:0] ast_event,
  input  wire logic                       pwm0_duty_match,
  // Enable write strobe and values
  input  wire logic                       en_load,
  input  wire event_router_pkg::cmp_vec_t gen_en_cmp_up,
  input  wire event_router_pkg::cmp_vec_t gen_en_cmp_dn,
  input  wire logic [event_router_pkg::NUM_PA_GRP-1:0] gen_en_pa,
  input  wire logic [event_router_pkg::NUM_PB_GRP-1:0] gen_en_pb,
  input  wire logic [event_router_pkg::NUM_AST_EV-1:0] gen_en_ast,
  input  wire logic                       gen_en_pwm0,
  input  wire logic [event_router_pkg::NUM_PWM-1:0]    usr_en_pwm,
  input  wire logic [event_router_pkg::NUM_PA_GRP-1:0] usr_en_tc0,
  input  wire logic [event_router_pkg::NUM_PB_GRP-1:0] usr_en_tc1,
  input  wire logic                       usr_en_cat,
  input  wire logic                       comparator_event_enable,
  input  wire logic [event_router_pkg::CMP_CFG_W-1:0]  comparator_channel_config,
  input  wire logic [event_router_pkg::ADC_TRG_W-1:0]  adc_trigger_mode_field,
  // User-side events
  output logic [event_router_pkg::NUM_PWM-1:0]    pwm_duty_inc,
  output logic [event_router_pkg::NUM_PWM-1:0]    pwm_duty_dec,
  output logic [event_router_pkg::NUM_PA_GRP-1:0] tc0_capture,
  output logic [event_router_pkg::NUM_PB_GRP-1:0] tc1_capture,
  output event_router_pkg::cmp_vec_t              cat_matrix_event,
  output logic                                    cmp_start_sync,
  output logic                                    adc_start_sync,
  output logic                                    cmp_start_async,
  output logic                                    adc_start_async,
  output logic                                    cat_iterate_async
);
  import event_router_pkg::*;

  // Enable registers
  cmp_vec_t              en_cmp_up, en_cmp_dn, next_en_cmp_up, next_en_cmp_dn;
  logic [NUM_PA_GRP-1:0] en_pa, next_en_pa, en_tc0, next_en_tc0;
  logic [NUM_PB_GRP-1:0] en_pb, next_en_pb, en_tc1, next_en_tc1;
  logic [NUM_AST_EV-1:0] en_ast, next_en_ast;
  logic [NUM_PWM-1:0]    en_pwm, next_en_pwm;
  logic                  en_pwm0, next_en_pwm0, en_cat, next_en_cat;
  logic                  cmp_evt_en, next_cmp_evt_en;
  logic [CMP_CFG_W-1:0]  cmp_cfg, next_cmp_cfg;
  logic [ADC_TRG_W-1:0]  adc_trg, next_adc_trg;

  always_comb begin
    next_en_cmp_up  = en_cmp_up;
    next_en_cmp_dn  = en_cmp_dn;
    next_en_pa      = en_pa;
    next_en_pb      = en_pb;
    next_en_ast     = en_ast;
    next_en_pwm0    = en_pwm0;
    next_en_pwm     = en_pwm;
    next_en_tc0     = en_tc0;
    next_en_tc1     = en_tc1;
    next_en_cat     = en_cat;
    next_cmp_evt_en = cmp_evt_en;
    next_cmp_cfg    = cmp_cfg;
    next_adc_trg    = adc_trg;
    if (en_load) begin
      next_en_cmp_up  = gen_en_cmp_up;
      next_en_cmp_dn  = gen_en_cmp_dn;
      next_en_pa      = gen_en_pa;
      next_en_pb      = gen_en_pb;
      next_en_ast     = gen_en_ast;
      next_en_pwm0    = gen_en_pwm0;
      next_en_pwm     = usr_en_pwm;
      next_en_tc0     = usr_en_tc0;
      next_en_tc1     = usr_en_tc1;
      next_en_cat     = usr_en_cat;
      next_cmp_evt_en = comparator_event_enable;
      next_cmp_cfg    = comparator_channel_config;
      next_adc_trg    = adc_trigger_mode_field;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      en_cmp_up  <= '0;
      en_cmp_dn  <= '0;
      en_pa      <= '0;
      en_pb      <= '0;
      en_ast     <= '0;
      en_pwm0    <= EN_RESET;
      en_pwm     <= '0;
      en_tc0     <= '0;
      en_tc1     <= '0;
      en_cat     <= EN_RESET;
      cmp_evt_en <= EN_RESET;
      cmp_cfg    <= '0;
      adc_trg    <= '0;
    end else begin
      en_cmp_up  <= next_en_cmp_up;
      en_cmp_dn  <= next_en_cmp_dn;
      en_pa      <= next_en_pa;
      en_pb      <= next_en_pb;
      en_ast     <= next_en_ast;
      en_pwm0    <= next_en_pwm0;
      en_pwm     <= next_en_pwm;
      en_tc0     <= next_en_tc0;
      en_tc1     <= next_en_tc1;
      en_cat     <= next_en_cat;
      cmp_evt_en <= next_cmp_evt_en;
      cmp_cfg    <= next_cmp_cfg;
      adc_trg    <= next_adc_trg;
    end
  end

  // Generator-side gating
  event_gate_if gated ();
  event_gen_gate u_gen_gate (
    .raw_cmp_up     (cmp_pos_above),
    .raw_cmp_dn     (cmp_neg_above),
    .raw_pa_chg     (pa_pin_change),
    .raw_pb_chg     (pb_pin_change),
    .raw_ast_ev     (ast_event),
    .raw_pwm0_match (pwm0_duty_match),
    .en_cmp_up      (en_cmp_up),
    .en_cmp_dn      (en_cmp_dn),
    .en_pa_chg      (en_pa),
    .en_pb_chg      (en_pb),
    .en_ast_ev      (en_ast),
    .en_pwm0_match  (en_pwm0),
    .gated          (gated)
  );

  // Fixed comparator to channel wiring, no selection register behind it
  function automatic logic [NUM_PWM-1:0] map_to_pwm(input cmp_vec_t ev);
    logic [NUM_PWM-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_CMP; i++) begin
      v[CMP_TO_PWM[i]] = v[CMP_TO_PWM[i]] | ev[i];
    end
    return v;
  endfunction

  // User-side gating and combination
  logic                  cmp_mode_ok, adc_mode_ok, ast_any;
  logic [NUM_PWM-1:0]    next_inc, next_dec;
  logic [NUM_PA_GRP-1:0] next_tc0;
  logic [NUM_PB_GRP-1:0] next_tc1;
  cmp_vec_t              next_cat;
  logic                  next_cmp_sync, next_adc_sync;

  always_comb begin
    cmp_mode_ok   = cmp_evt_en && (cmp_cfg == CMP_CFG_EVENT_SINGLE);
    adc_mode_ok   = (adc_trg == ADC_TRG_PERIPH_EVENT);
    ast_any       = |gated.ast_ev;
    next_inc      = map_to_pwm(gated.cmp_up) & en_pwm;
    next_dec      = map_to_pwm(gated.cmp_dn) & en_pwm;
    next_tc0      = gated.pa_chg & en_tc0;
    next_tc1      = gated.pb_chg & en_tc1;
    next_cat      = gated.cmp_dn & {NUM_CMP{en_cat}};
    next_cmp_sync = gated.pwm0_match & cmp_mode_ok;
    next_adc_sync = gated.pwm0_match & adc_mode_ok;
  end

  // Synchronous events registered: one fixed cycle of latency
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwm_duty_inc     <= '0;
      pwm_duty_dec     <= '0;
      tc0_capture      <= '0;
      tc1_capture      <= '0;
      cat_matrix_event <= '0;
      cmp_start_sync   <= PULSE_RESET;
      adc_start_sync   <= PULSE_RESET;
    end else begin
      pwm_duty_inc     <= next_inc;
      pwm_duty_dec     <= next_dec;
      tc0_capture      <= next_tc0;
      tc1_capture      <= next_tc1;
      cat_matrix_event <= next_cat;
      cmp_start_sync   <= next_cmp_sync;
      adc_start_sync   <= next_adc_sync;
    end
  end

  // Asynchronous timer events: pure gating so they pass with the clock stopped
  always_comb begin
    cmp_start_async   = ast_any & cmp_mode_ok;
    adc_start_async   = ast_any & adc_mode_ok;
    cat_iterate_async = ast_any & en_cat;
  end

  // Assertions
  AST_INC_MAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmp_pos_above[1] && en_cmp_up[1] && en_pwm[6]) |=> pwm_duty_inc[6])
    else $error("comparator 1 increment not routed to channel 6");
  AST_DEC_MAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmp_neg_above[7] && en_cmp_dn[7] && en_pwm[20]) |=> pwm_duty_dec[20])
    else $error("comparator 7 decrement not routed to channel 20");
  AST_USER_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !en_pwm[6] |=> !pwm_duty_inc[6])
    else $error("disabled user received event");
  AST_CAT_ROUTE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmp_neg_above[2] && en_cmp_dn[2] && en_cat) |=> cat_matrix_event[2])
    else $error("touch module missed comparator event");
  AST_TC0_CAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pa_pin_change[1] && en_pa[1] && en_tc0[1]) |=> tc0_capture[1])
    else $error("port A change not captured");
  AST_TC1_CAP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tc1_capture[0] |-> $past(pb_pin_change[0] && en_pb[0] && en_tc1[0]))
    else $error("spurious second timer capture");
  AST_AST_CMP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmp_start_async |-> (cmp_cfg == 2'h3 && cmp_evt_en && |ast_event))
    else $error("comparator start without its conditions");
  AST_PWM0_ADC: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pwm0_duty_match && en_pwm0 && adc_trg == 3'h7) |=> adc_start_sync)
    else $error("channel 0 match did not start conversion");
  AST_CAT_ITER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ast_event[2] && en_ast[2] && en_cat) |-> cat_iterate_async)
    else $error("alarm event missed touch iteration");
  AST_RESET_EN: assert property (@(posedge sys_clk)
    !rst_n |=> (en_pwm == '0 && !en_cat && en_ast == '0))
    else $error("enables not cleared by reset");
endmodule

// File: sim/event_source_model.sv
// Stand-in for the peripheral event generators feeding the router
`timescale 1ns/1ps
module event_source_model (
  // Clock
  input  wire logic                                    sys_clk,
  // Raw events
  output event_router_pkg::cmp_vec_t                   cmp_pos_above,
  output event_router_pkg::cmp_vec_t                   cmp_neg_above,
  output logic [event_router_pkg::NUM_PA_GRP-1:0]      pa_pin_change,
  output logic [event_router_pkg::NUM_PB_GRP-1:0]      pb_pin_change,
  output logic [event_router_pkg::NUM_AST_EV-1:0]      ast_event,
  output logic                                         pwm0_duty_match
);
  import event_router_pkg::*;
  initial begin
    {cmp_pos_above, cmp_neg_above, pa_pin_change, pb_pin_change, ast_event, pwm0_duty_match} = '0;
  end
  // One-cycle pulse from each generator, launched just after an edge
  task automatic pulse(input cmp_vec_t up, input cmp_vec_t dn, input logic [2:0] pa, input logic [1:0] pb,
                       input logic [2:0] ast, input logic m);
    {cmp_pos_above, cmp_neg_above, pa_pin_change, pb_pin_change, ast_event, pwm0_duty_match} =
      {up, dn, pa, pb, ast, m};
    @(posedge sys_clk);
    #1;
    {cmp_pos_above, cmp_neg_above, pa_pin_change, pb_pin_change, ast_event, pwm0_duty_match} = '0;
  endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the fixed event router
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
  import event_router_pkg::*;
  typedef struct packed {
    cmp_vec_t up; cmp_vec_t dn; logic [2:0] pa; logic [1:0] pb; logic [2:0] ast; logic m;
    logic [35:0] pwm; logic [2:0] t0; logic [1:0] t1; logic capacitive_touch_module; logic ev; logic [1:0] cfg; logic [2:0] trg;
  } en_set_t;
  localparam int MAP [8] = '{0, 6, 8, 9, 11, 14, 19, 20};
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        en_load = 1'b0;
  en_set_t     drv     = '0;
  en_set_t     sh      = '0;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles  = 0;
  cmp_vec_t    cmp_pos_above, cmp_neg_above, cat_matrix_event;
  logic [2:0]  pa_pin_change, ast_event, tc0_capture;
  logic [1:0]  pb_pin_change, tc1_capture;
  logic [35:0] pwm_duty_inc, pwm_duty_dec;
  logic        pwm0_duty_match, cmp_start_sync, adc_start_sync, cmp_start_async, adc_start_async, cat_iterate_async;
  always #12.5 sys_clk = ~sys_clk;
  event_source_model u_src (.sys_clk(sys_clk), .cmp_pos_above(cmp_pos_above), .cmp_neg_above(cmp_neg_above),
    .pa_pin_change(pa_pin_change), .pb_pin_change(pb_pin_change), .ast_event(ast_event),
    .pwm0_duty_match(pwm0_duty_match));
  fixed_event_router u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .cmp_pos_above(cmp_pos_above),
    .cmp_neg_above(cmp_neg_above), .pa_pin_change(pa_pin_change), .pb_pin_change(pb_pin_change),
    .ast_event(ast_event), .pwm0_duty_match(pwm0_duty_match), .en_load(en_load), .gen_en_cmp_up(drv.up),
    .gen_en_cmp_dn(drv.dn), .gen_en_pa(drv.pa), .gen_en_pb(drv.pb), .gen_en_ast(drv.ast), .gen_en_pwm0(drv.m),
    .usr_en_pwm(drv.pwm), .usr_en_tc0(drv.t0), .usr_en_tc1(drv.t1), .usr_en_cat(drv.capacitive_touch_module),
    .comparator_event_enable(drv.ev), .comparator_channel_config(drv.cfg), .adc_trigger_mode_field(drv.trg),
    .pwm_duty_inc(pwm_duty_inc), .pwm_duty_dec(pwm_duty_dec), .tc0_capture(tc0_capture),
    .tc1_capture(tc1_capture), .cat_matrix_event(cat_matrix_event), .cmp_start_sync(cmp_start_sync),
    .adc_start_sync(adc_start_sync), .cmp_start_async(cmp_start_async), .adc_start_async(adc_start_async),
    .cat_iterate_async(cat_iterate_async));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Enables become live for events sampled after the loading edge
  task automatic load();
    en_load = 1'b1;
    @(posedge sys_clk);
    #1;
    en_load = 1'b0;
    sh      = drv;
  endtask
  task automatic do_reset(input int n);
    rst_n = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    sh    = '0;
  endtask
  // Fire one set of events and compare every user output
  task automatic ev(input cmp_vec_t up, input cmp_vec_t dn, input logic [2:0] pa, input logic [1:0] pb,
                    input logic [2:0] ast, input logic m);
    logic [35:0] ei, ed;
    logic        a, cs, as;
    ei = '0;
    ed = '0;
    for (int i = 0; i < 8; i++) begin
      ei[MAP[i]] = up[i] & sh.up[i] & sh.pwm[MAP[i]];
      ed[MAP[i]] = dn[i] & sh.dn[i] & sh.pwm[MAP[i]];
    end
    a  = |(ast & sh.ast);
    cs = sh.ev && sh.cfg == 2'h3;
    as = sh.trg == 3'h7;
    fork
      u_src.pulse(up, dn, pa, pb, ast, m);
      begin
        #2;
        `CHK("cmp_start_async", a & cs, cmp_start_async)
        `CHK("adc_start_async", a & as, adc_start_async)
        `CHK("cat_iterate_async", a & sh.capacitive_touch_module, cat_iterate_async)
      end
    join
    `CHK("pwm_duty_inc", ei, pwm_duty_inc)
    `CHK("pwm_duty_dec", ed, pwm_duty_dec)
    `CHK("tc0_capture", pa & sh.pa & sh.t0, tc0_capture)
    `CHK("tc1_capture", pb & sh.pb & sh.t1, tc1_capture)
    `CHK("cat_matrix_event", dn & sh.dn & {8{sh.capacitive_touch_module}}, cat_matrix_event)
    `CHK("cmp_start_sync", m & sh.m & cs, cmp_start_sync)
    `CHK("adc_start_sync", m & sh.m & as, adc_start_sync)
    @(posedge sys_clk);
    #1;
    `CHK("sync idle", 87'h0, {pwm_duty_inc, pwm_duty_dec, tc0_capture, tc1_capture, cat_matrix_event,
      cmp_start_sync, adc_start_sync})
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    do_reset(12);
    drv = '1;
    ev('1, '1, '1, '1, '1, 1'b1);
    load();
    for (int i = 0; i < 8; i++) begin
      ev(8'h1 << i, 8'h0, 3'h0, 2'h0, 3'h0, 1'b0);
      ev(8'h0, 8'h1 << i, 3'h0, 2'h0, 3'h0, 1'b0);
    end
    for (int g = 0; g < 3; g++) begin
      ev(8'h0, 8'h0, 3'h1 << g, 2'h1 << g, 3'h1 << g, 1'b0);
    end
    ev(8'h0, 8'h0, 3'h0, 2'h0, 3'h0, 1'b1);
    ev('1, '1, '1, '1, '1, 1'b1);
    drv.pwm[6] = 1'b0;
    drv.dn[2]  = 1'b0;
    drv.ast    = 3'h5;
    drv.t0[1]  = 1'b0;
    drv.pb[0]  = 1'b0;
    load();
    ev(8'h06, 8'h06, 3'h2, 2'h3, 3'h2, 1'b0);
    ev(8'h06, 8'h06, 3'h3, 2'h1, 3'h1, 1'b0);
    drv.cfg = 2'h2;
    drv.trg = 3'h6;
    drv.capacitive_touch_module = 1'b0;
    load();
    ev(8'h0, 8'hFF, 3'h0, 2'h0, 3'h4, 1'b1);
    drv.cfg = 2'h3;
    drv.ev  = 1'b0;
    drv.trg = 3'h7;
    load();
    ev(8'h0, 8'h0, 3'h0, 2'h0, 3'h1, 1'b1);
    do_reset(2);
    drv = '1;
    ev('1, '1, '1, '1, '1, 1'b1);
    summarize();
  end
endmodule
